//--- src/sset_pkg.sv
// Package with the constants, selects and carriers of the status event summary tree
package sset_pkg;

   // ---------------------------------------------------------------
   // Widths and chains
   // ---------------------------------------------------------------
   localparam int SSET_W          = 16;
   localparam int SSET_NCHAIN     = 3;
   localparam int SSET_NLEVEL     = 3;
   localparam int SSET_CH_OPER    = 0;
   localparam int SSET_CH_QUES    = 1;
   localparam int SSET_CH_MEAS    = 2;
   localparam int SSET_LV_SUM     = 0;
   localparam int SSET_LV_INST    = 1;
   localparam int SSET_LV_TOP     = 2;

   // ---------------------------------------------------------------
   // Bit positions
   // ---------------------------------------------------------------
   localparam int SSET_TOP_SUM_BIT   = 13;
   localparam int SSET_INST_SUM_BIT  = 1;
   localparam int OP_CALIBRATING_BIT = 0;
   localparam int OP_MEASURING_BIT   = 4;
   localparam int OP_TRIG_WAIT_BIT   = 5;
   localparam int OP_ARM_WAIT_BIT    = 6;
   localparam int OP_FILTER_OK_BIT   = 8;
   localparam int OP_LIST_RUN_BIT    = 9;
   localparam int OP_IDLE_BIT        = 10;
   localparam int QU_CC_BIT          = 0;
   localparam int QU_CV_BIT          = 1;
   localparam int QU_OCP_BIT         = 2;
   localparam int QU_OVP_BIT         = 3;
   localparam int QU_OTP_BIT         = 4;
   localparam int QU_SENSE_REV_BIT   = 5;
   localparam int QU_DRIVING_BIT     = 6;
   localparam int ME_OVERFLOW_BIT    = 0;
   localparam int ME_READY_BIT       = 6;
   localparam int ME_HALF_BIT        = 7;
   localparam int ME_FULL_BIT        = 8;
   localparam int ME_THREE_Q_BIT     = 9;
   localparam int ME_ONE_Q_BIT       = 10;
   localparam int SB_OPERATION_BIT   = 7;
   localparam int SB_QUESTIONABLE_BIT = 3;
   localparam int SB_MEASUREMENT_BIT = 0;

   // ---------------------------------------------------------------
   // Used-bit masks and reset values
   // ---------------------------------------------------------------
   localparam logic [SSET_W-1:0] SSET_TOP_USED  = 16'h2000;
   localparam logic [SSET_W-1:0] SSET_INST_USED = 16'h0002;
   localparam logic [SSET_W-1:0] SSET_OPER_USED = 16'h0771;
   localparam logic [SSET_W-1:0] SSET_QUES_USED = 16'h007f;
   localparam logic [SSET_W-1:0] SSET_MEAS_USED = 16'h07c1;
   localparam logic [SSET_W-1:0] SSET_EV_RST    = 16'h0000;
   localparam logic [SSET_W-1:0] SSET_EN_RST    = 16'h0000;
   localparam logic [7:0]        SSET_SB_RST    = 8'h00;

   // ---------------------------------------------------------------
   // Register selects: per chain, events, enables, then condition
   // ---------------------------------------------------------------
   localparam int SSET_SEL_STRIDE = 7;
   localparam int SSET_SEL_EN_OFS = 3;
   localparam int SSET_SEL_CO_OFS = 6;

   typedef enum logic [4:0] {
      SEL_OPER_SUM_EV, SEL_OPER_INST_EV, SEL_OPER_TOP_EV,
      SEL_OPER_SUM_EN, SEL_OPER_INST_EN, SEL_OPER_TOP_EN, SEL_OPER_COND,
      SEL_QUES_SUM_EV, SEL_QUES_INST_EV, SEL_QUES_TOP_EV,
      SEL_QUES_SUM_EN, SEL_QUES_INST_EN, SEL_QUES_TOP_EN, SEL_QUES_COND,
      SEL_MEAS_SUM_EV, SEL_MEAS_INST_EV, SEL_MEAS_TOP_EV,
      SEL_MEAS_SUM_EN, SEL_MEAS_INST_EN, SEL_MEAS_TOP_EN, SEL_MEAS_COND
   } sset_sel_e;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic              write;
      sset_sel_e         sel;
      logic [SSET_W-1:0] data;
   } sset_cmd_s;

   typedef struct packed {
      logic idle;
      logic list_run;
      logic filter_settled;
      logic arm_wait;
      logic trig_wait;
      logic measuring;
      logic calibrating;
   } sset_oper_cond_s;

   typedef struct packed {
      logic terminal_driving;
      logic sense_leads_reversed;
      logic over_temp_trip;
      logic over_voltage_trip;
      logic over_current_trip;
      logic constant_voltage;
      logic constant_current;
   } sset_ques_cond_s;

   typedef struct packed {
      logic fill_one_quarter;
      logic fill_three_quarter;
      logic fill_complete;
      logic fill_half;
      logic reading_ready;
      logic reading_overflow;
   } sset_meas_cond_s;

endpackage

//--- src/sset_cond_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse per condition bit
`timescale 1ns/1ns
`default_nettype none

module sset_cond_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] raw_i,
   output var  logic [WIDTH-1:0] level_o,
   output var  logic [WIDTH-1:0] rise_o
);

   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         logic s1_r, s2_r, s3_r;
         // First stage feeds only the second stage
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
            end else if (ce_i) begin
               s1_r <= raw_i[b];
               s2_r <= s1_r;
               s3_r <= s2_r;
            end
         end
         // A change counts once the second and third stages agree
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               level_o[b] <= 1'b0;
               rise_o[b]  <= 1'b0;
            end else if (ce_i) begin
               if (s2_r == s3_r) begin
                  level_o[b] <= s3_r;
               end
               rise_o[b] <= (s2_r == s3_r) && s3_r && !level_o[b]; // R19
            end
         end
      end
   endgenerate

endmodule // sset_cond_sync

`default_nettype wire

//--- src/sset_evt_reg.sv
// One latched event register with its enable register and summary output
`timescale 1ns/1ns
`default_nettype none

module sset_evt_reg
   import sset_pkg::*;
#(
   parameter logic [SSET_W-1:0] USED_MASK = 16'hffff
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic [SSET_W-1:0] set_i,
   input  wire logic              rd_clr_i,
   input  wire logic              cls_i,
   input  wire logic              en_wr_i,
   input  wire logic [SSET_W-1:0] en_data_i,
   output var  logic [SSET_W-1:0] event_o,
   output var  logic [SSET_W-1:0] enable_o,
   output var  logic              summary_o,
   output var  logic              summary_rise_o
);

   logic [SSET_W-1:0] event_r, event_nxt;
   logic [SSET_W-1:0] enable_r;
   logic              summary_r;

   // Set wins over a clear landing in the same cycle
   always_comb begin
      event_nxt = ((rd_clr_i || cls_i) ? SSET_EV_RST : event_r) | (set_i & USED_MASK); // R14 R18
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_r <= SSET_EV_RST;
      end else if (ce_i) begin
         event_r <= event_nxt; // R14
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_r <= SSET_EN_RST;
      end else if (ce_i && en_wr_i) begin
         enable_r <= en_data_i & USED_MASK; // R15 R18
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         summary_r <= 1'b0;
      end else if (ce_i) begin
         summary_r <= summary_o;
      end
   end

   assign event_o        = event_r;
   assign enable_o       = enable_r;
   assign summary_o      = |(event_r & enable_r); // R15
   assign summary_rise_o = summary_o && !summary_r;

endmodule // sset_evt_reg

`default_nettype wire

//--- src/sset_tree.sv
// Top of the status event summary tree: three chains, condition inputs, command port
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (R01) Operation top bit 13 sets on enabled operation instrument bit 1.
// (R02) Operation instrument bit 1 is the masked operation summary rollup.
// (R03) Operation summary: bit0 calibrating, 4 measuring, 5 trigger wait, 6 arm wait.
// (R04) Operation summary: bit8 filter settled, 9 list running, 10 idle.
// (R05) Questionable top bit 13 sets on enabled questionable instrument bit 1.
// (R06) Questionable instrument bit 1 is the masked questionable summary rollup.
// (R07) Questionable summary: bit0 constant current, bit1 constant voltage.
// (R08) Questionable summary: bit2 overcurrent trip, bit3 overvoltage trip.
// (R09) Questionable summary: bit4 overtemperature, 5 sense reversed, 6 output on.
// (R10) Measurement top bit 13 sets on enabled measurement instrument bit 1.
// (R11) Measurement instrument bit 1 is the masked measurement summary rollup.
// (R12) Measurement summary: bit0 reading overflow, bit6 reading ready.
// (R13) Measurement summary fill: bit10 quarter, 7 half, 9 three quarter, 8 full.
// (R14) Event bits latch at one; read clears register; clear-status clears all.
// (R15) Each event register has an enable; summary is OR of enabled bits.
// (R16) Read-only condition registers follow present state without latching.
// (R17) Top summaries drive status byte bits 7, 3 and 0.
// (R18) Unused bits read zero; enable writes to them are ignored.
// (R19) Summary event bit sets when its condition is first seen rising.
module sset_tree
   import sset_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire sset_oper_cond_s   oper_cond_i,
   input  wire sset_ques_cond_s   ques_cond_i,
   input  wire sset_meas_cond_s   meas_cond_i,
   input  wire sset_cmd_s         cmd_i,
   input  wire logic              cls_i,
   output var  logic [SSET_W-1:0] rd_data_o,
   output var  logic              rd_valid_o,
   output var  logic [7:0]        status_summary_o
);

   // ---------------------------------------------------------------
   // Condition inputs placed at their register positions
   // ---------------------------------------------------------------
   logic [SSET_W-1:0] cond_raw   [SSET_NCHAIN];
   logic [SSET_W-1:0] cond_level [SSET_NCHAIN];
   logic [SSET_W-1:0] cond_rise  [SSET_NCHAIN];

   always_comb begin
      cond_raw[SSET_CH_OPER]                     = '0;
      cond_raw[SSET_CH_OPER][OP_CALIBRATING_BIT] = oper_cond_i.calibrating;    // R03
      cond_raw[SSET_CH_OPER][OP_MEASURING_BIT]   = oper_cond_i.measuring;      // R03
      cond_raw[SSET_CH_OPER][OP_TRIG_WAIT_BIT]   = oper_cond_i.trig_wait;      // R03
      cond_raw[SSET_CH_OPER][OP_ARM_WAIT_BIT]    = oper_cond_i.arm_wait;       // R03
      cond_raw[SSET_CH_OPER][OP_FILTER_OK_BIT]   = oper_cond_i.filter_settled; // R04
      cond_raw[SSET_CH_OPER][OP_LIST_RUN_BIT]    = oper_cond_i.list_run;       // R04
      cond_raw[SSET_CH_OPER][OP_IDLE_BIT]        = oper_cond_i.idle;           // R04
   end

   always_comb begin
      cond_raw[SSET_CH_QUES]                   = '0;
      cond_raw[SSET_CH_QUES][QU_CC_BIT]        = ques_cond_i.constant_current;     // R07
      cond_raw[SSET_CH_QUES][QU_CV_BIT]        = ques_cond_i.constant_voltage;     // R07
      cond_raw[SSET_CH_QUES][QU_OCP_BIT]       = ques_cond_i.over_current_trip;    // R08
      cond_raw[SSET_CH_QUES][QU_OVP_BIT]       = ques_cond_i.over_voltage_trip;    // R08
      cond_raw[SSET_CH_QUES][QU_OTP_BIT]       = ques_cond_i.over_temp_trip;       // R09
      cond_raw[SSET_CH_QUES][QU_SENSE_REV_BIT] = ques_cond_i.sense_leads_reversed; // R09
      cond_raw[SSET_CH_QUES][QU_DRIVING_BIT]   = ques_cond_i.terminal_driving;     // R09
   end

   always_comb begin
      cond_raw[SSET_CH_MEAS]                  = '0;
      cond_raw[SSET_CH_MEAS][ME_OVERFLOW_BIT] = meas_cond_i.reading_overflow;   // R12
      cond_raw[SSET_CH_MEAS][ME_READY_BIT]    = meas_cond_i.reading_ready;      // R12
      cond_raw[SSET_CH_MEAS][ME_ONE_Q_BIT]    = meas_cond_i.fill_one_quarter;   // R13
      cond_raw[SSET_CH_MEAS][ME_HALF_BIT]     = meas_cond_i.fill_half;          // R13
      cond_raw[SSET_CH_MEAS][ME_THREE_Q_BIT]  = meas_cond_i.fill_three_quarter; // R13
      cond_raw[SSET_CH_MEAS][ME_FULL_BIT]     = meas_cond_i.fill_complete;      // R13
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic cmd_rd;
   logic cmd_wr;
   int   sel_idx;

   assign cmd_rd  = cmd_i.valid && !cmd_i.write;
   assign cmd_wr  = cmd_i.valid && cmd_i.write;
   assign sel_idx = int'(cmd_i.sel);

   // ---------------------------------------------------------------
   // Per-chain datapath: summary, instrument and top event registers
   // ---------------------------------------------------------------
   logic [SSET_W-1:0] ev_val  [SSET_NCHAIN][SSET_NLEVEL];
   logic [SSET_W-1:0] en_val  [SSET_NCHAIN][SSET_NLEVEL];
   logic [SSET_W-1:0] ev_set  [SSET_NCHAIN][SSET_NLEVEL];
   logic              lv_sum  [SSET_NCHAIN][SSET_NLEVEL];
   logic              lv_rise [SSET_NCHAIN][SSET_NLEVEL];
   logic [SSET_W-1:0] cond_rd [SSET_NCHAIN];

   localparam logic [SSET_W-1:0] SUM_USED [SSET_NCHAIN] = '{SSET_OPER_USED, SSET_QUES_USED, SSET_MEAS_USED};

   genvar c, l;
   generate
      for (c = 0; c < SSET_NCHAIN; c++) begin : g_chain
         sset_cond_sync #(
            .WIDTH (SSET_W)
         ) u_sync (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .ce_i    (ce_i),
            .raw_i   (cond_raw[c]),
            .level_o (cond_level[c]),
            .rise_o  (cond_rise[c])
         );

         // Condition register never latches: it is the filtered live level
         assign cond_rd[c] = cond_level[c] & SUM_USED[c]; // R16 R18

         // Bottom level takes condition rises; upper levels take the rise of the level below
         assign ev_set[c][SSET_LV_SUM] = cond_rise[c]; // R19
         always_comb begin
            ev_set[c][SSET_LV_INST]                    = '0;
            ev_set[c][SSET_LV_INST][SSET_INST_SUM_BIT] = lv_rise[c][SSET_LV_SUM];  // R02 R06 R11
            ev_set[c][SSET_LV_TOP]                     = '0;
            ev_set[c][SSET_LV_TOP][SSET_TOP_SUM_BIT]   = lv_rise[c][SSET_LV_INST]; // R01 R05 R10
         end

         for (l = 0; l < SSET_NLEVEL; l++) begin : g_level
            localparam logic [SSET_W-1:0] USED =
               (l == SSET_LV_SUM)  ? SUM_USED[c] :
               (l == SSET_LV_INST) ? SSET_INST_USED : SSET_TOP_USED;
            logic hit_ev;
            logic hit_en;

            assign hit_ev = (sel_idx == c * SSET_SEL_STRIDE + l);
            assign hit_en = (sel_idx == c * SSET_SEL_STRIDE + SSET_SEL_EN_OFS + l);

            sset_evt_reg #(
               .USED_MASK (USED)
            ) u_evt (
               .clk_i          (clk_i),
               .rst_i          (rst_i),
               .ce_i           (ce_i),
               .set_i          (ev_set[c][l]),
               .rd_clr_i       (cmd_rd && hit_ev), // R14
               .cls_i          (cls_i),            // R14
               .en_wr_i        (cmd_wr && hit_en), // R15
               .en_data_i      (cmd_i.data),
               .event_o        (ev_val[c][l]),
               .enable_o       (en_val[c][l]),
               .summary_o      (lv_sum[c][l]),
               .summary_rise_o (lv_rise[c][l])
            );
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------
   logic [SSET_W-1:0] rd_mux;

   // Unmapped selects read zero rather than stale data
   always_comb begin
      rd_mux = '0;
      for (int i = 0; i < SSET_NCHAIN; i++) begin
         for (int j = 0; j < SSET_NLEVEL; j++) begin
            if (sel_idx == i * SSET_SEL_STRIDE + j) begin
               rd_mux = ev_val[i][j];
            end
            if (sel_idx == i * SSET_SEL_STRIDE + SSET_SEL_EN_OFS + j) begin
               rd_mux = en_val[i][j];
            end
         end
         if (sel_idx == i * SSET_SEL_STRIDE + SSET_SEL_CO_OFS) begin
            rd_mux = cond_rd[i]; // R16
         end
      end
   end

   // ---------------------------------------------------------------
   // Read response
   // ---------------------------------------------------------------
   // The value returned is the one held before the clear of the same edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o  <= '0;
         rd_valid_o <= 1'b0;
      end else if (ce_i) begin
         rd_valid_o <= cmd_rd;
         if (cmd_rd) begin
            rd_data_o <= rd_mux; // R18
         end
      end
   end

   // ---------------------------------------------------------------
   // Status byte summary bits
   // ---------------------------------------------------------------
   logic [7:0] sb_nxt;

   always_comb begin
      sb_nxt                      = SSET_SB_RST;
      sb_nxt[SB_OPERATION_BIT]    = lv_sum[SSET_CH_OPER][SSET_LV_TOP]; // R17
      sb_nxt[SB_QUESTIONABLE_BIT] = lv_sum[SSET_CH_QUES][SSET_LV_TOP]; // R17
      sb_nxt[SB_MEASUREMENT_BIT]  = lv_sum[SSET_CH_MEAS][SSET_LV_TOP]; // R17
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_summary_o <= SSET_SB_RST;
      end else if (ce_i) begin
         status_summary_o <= sb_nxt;
      end
   end

endmodule // sset_tree

`default_nettype wire

//--- dv/sset_tree_sva.sv
// Concurrent checks on the ports of the status event summary tree
`timescale 1ns/1ns
`default_nettype none

module sset_tree_sva
   import sset_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire sset_oper_cond_s   oper_cond_i,
   input  wire sset_ques_cond_s   ques_cond_i,
   input  wire sset_meas_cond_s   meas_cond_i,
   input  wire sset_cmd_s         cmd_i,
   input  wire logic              cls_i,
   input  wire logic [SSET_W-1:0] rd_data_o,
   input  wire logic              rd_valid_o,
   input  wire logic [7:0]        status_summary_o
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   logic [3:0]  up_cnt_r;
   logic        rd_req;
   logic        ev_sel;
   logic [15:0] used_m;
   logic [15:0] oper_map;
   assign rd_req   = ce_i & cmd_i.valid & ~cmd_i.write;
   assign ev_sel   = (int'(cmd_i.sel) % 7) < 3;
   assign used_m   = (int'(cmd_i.sel) % 7 == 1) ? SSET_INST_USED : SSET_TOP_USED;
   assign oper_map = {5'h0, oper_cond_i[6:4], 1'b0, oper_cond_i[3:1], 3'h0, oper_cond_i[0]};

   // Sync stages hold stale values for a while after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_cnt_r <= 4'h0;
      end else if (up_cnt_r != 4'hf) begin
         up_cnt_r <= up_cnt_r + 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   // Twelve quiet cycles drain the whole condition pipeline
   sequence calm_s;
      up_cnt_r == 4'hf && !cmd_i.valid && !cls_i && $stable(oper_cond_i)
         && $stable(ques_cond_i) && $stable(meas_cond_i);
   endsequence
   sequence quiet_s;
      calm_s[*8] ##1 calm_s[*4];
   endsequence
   sequence wr_en_s;
      cmd_i.valid && cmd_i.write && cmd_i.sel == SEL_OPER_SUM_EN;
   endsequence
   sequence rd_en_s;
      rd_req && cmd_i.sel == SEL_OPER_SUM_EN;
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   rd_answer_a:
   assert property (rd_req |=> rd_valid_o) else $error("read got no answer");
   rd_cause_a:
   assert property (rd_valid_o |-> $past(rd_req)) else $error("answer without read");
   sb_unused_a:
   assert property ((status_summary_o & 8'h76) == 8'h00) else $error("unused status bit set");
   top_unused_a:
   assert property (rd_req && ev_sel && int'(cmd_i.sel) % 7 != 0 |=> (rd_data_o & ~$past(used_m)) == 16'h0)
      else $error("unused event bit read as one");
   en_mask_a:
   assert property (wr_en_s ##1 rd_en_s |=> rd_data_o == ($past(cmd_i.data, 2) & SSET_OPER_USED))
      else $error("enable readback wrong");
   cond_track_a:
   assert property (quiet_s ##1 (rd_req && cmd_i.sel == SEL_OPER_COND && $stable(oper_cond_i))
      |=> rd_data_o == $past(oper_map)) else $error("condition register wrong");
   rd_clear_a:
   assert property (quiet_s ##1 (rd_req && ev_sel) ##1 (rd_req && $stable(cmd_i.sel))
      |=> rd_data_o == 16'h0) else $error("read did not clear events");
   cls_clear_a:
   assert property (quiet_s ##1 cls_i ##1 (rd_req && ev_sel) |=> rd_data_o == 16'h0)
      else $error("clear status left events");
   sb_hold_a:
   assert property (quiet_s |-> $stable(status_summary_o)) else $error("status moved while quiet");

endmodule // sset_tree_sva

`default_nettype wire

//--- dv/test_sset_tree.sv
// Self-checking bench for the status event summary tree
`timescale 1ns/1ns
`default_nettype none

module test_sset_tree
   import sset_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and tables
   // ---------------------------------------------------------------
   localparam logic [15:0] WT [3][7] = '{
      '{16'h0001, 16'h0010, 16'h0020, 16'h0040, 16'h0100, 16'h0200, 16'h0400},
      '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040},
      '{16'h0001, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0000}};
   localparam logic [7:0]  SB [3]   = '{8'h80, 8'h08, 8'h01};
   localparam logic [15:0] USED [3] = '{SSET_OPER_USED, SSET_QUES_USED, SSET_MEAS_USED};
   localparam int          NBIT [3] = '{7, 7, 6};

   logic            clk_i;
   logic            rst_i;
   logic            ce_i;
   sset_oper_cond_s oper_cond_i;
   sset_ques_cond_s ques_cond_i;
   sset_meas_cond_s meas_cond_i;
   sset_cmd_s       cmd_i;
   logic            cls_i;
   logic [15:0]     rd_data_o;
   logic            rd_valid_o;
   logic [7:0]      status_summary_o;
   int              bad_count;
   int              total_checks;
   int              cyc;

   sset_tree u_dut (.clk_i, .rst_i, .ce_i, .oper_cond_i, .ques_cond_i, .meas_cond_i,
      .cmd_i, .cls_i, .rd_data_o, .rd_valid_o, .status_summary_o);

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      cmd_i = '0;
      cls_i = 1'b0;
      repeat (n) @(negedge clk_i);
   endtask

   task automatic wr(input int sel, input logic [15:0] d);
      cmd_i = {1'b1, 1'b1, sset_sel_e'(sel), d};
      @(negedge clk_i);
   endtask

   task automatic rd(input int sel, input logic [15:0] exp);
      cmd_i = {1'b1, 1'b0, sset_sel_e'(sel), 16'h0};
      @(negedge clk_i);
      chk("rd_valid", 16'h0001, {15'h0, rd_valid_o});
      chk($sformatf("sel %0d", sel), exp, rd_data_o);
   endtask

   task automatic cond(input int ch, input logic [6:0] v);
      case (ch)
         0: oper_cond_i = v;
         1: ques_cond_i = v;
         default: meas_cond_i = v[5:0];
      endcase
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs about 920 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      oper_cond_i = '0;
      ques_cond_i = '0;
      meas_cond_i = '0;
      cmd_i = '0;
      cls_i = 1'b0;
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      for (int s = 0; s < 21; s++) rd(s, 16'h0);
      rd(25, 16'h0);
      // Event and condition selects ignore writes; enables keep used bits only
      for (int c = 0; c < 3; c++) begin
         for (int l = 0; l < 7; l++) begin
            wr(c * 7 + l, 16'hffff);
            rd(c * 7 + l, l == 3 ? USED[c] : l == 4 ? SSET_INST_USED : l == 5 ? SSET_TOP_USED : 16'h0);
         end
      end
      for (int c = 0; c < 3; c++) begin
         for (int b = 0; b < NBIT[c]; b++) begin
            cond(c, 7'(1 << b));
            tick(16);
            chk("status", {8'h0, SB[c]}, {8'h0, status_summary_o});
            rd(c * 7, WT[c][b]);
            rd(c * 7, 16'h0);
            rd(c * 7 + 1, 16'h0002);
            rd(c * 7 + 2, 16'h2000);
            rd(c * 7 + 6, WT[c][b]);
            cond(c, 7'h0);
            tick(16);
            chk("status", 16'h0, {8'h0, status_summary_o});
            rd(c * 7 + 6, 16'h0);
         end
      end
      // Summary masked off, then enabled late while the bit is held
      wr(3, 16'h0);
      cond(0, 7'h40);
      tick(16);
      rd(6, 16'h0400);
      rd(1, 16'h0);
      chk("status", 16'h0, {8'h0, status_summary_o});
      wr(3, 16'h0400);
      tick(16);
      chk("status", 16'h0080, {8'h0, status_summary_o});
      rd(1, 16'h0002);
      tick(16);
      cls_i = 1'b1;
      @(negedge clk_i);
      cls_i = 1'b0;
      rd(0, 16'h0);
      rd(2, 16'h0);
      tick(4);
      chk("status", 16'h0, {8'h0, status_summary_o});
      rd(3, 16'h0400);
      cond(0, 7'h0);
      tick(4);
      // ---------------------------------------------------------------
      // Low clock enable freezes the condition pipeline and the read port
      // ---------------------------------------------------------------
      ce_i = 1'b0;
      cond(1, 7'h01);
      cmd_i = {1'b1, 1'b0, SEL_QUES_COND, 16'h0};
      repeat (8) @(negedge clk_i);
      chk("frozen rd_valid", 16'h0, {15'h0, rd_valid_o});
      chk("frozen status", 16'h0, {8'h0, status_summary_o});
      ce_i = 1'b1;
      rd(13, 16'h0);
      tick(16);
      chk("status", 16'h0008, {8'h0, status_summary_o});
      rd(13, 16'h0001);
      give_verdict();
   end

endmodule // test_sset_tree

bind sset_tree sset_tree_sva u_sva (.clk_i, .rst_i, .ce_i, .oper_cond_i, .ques_cond_i, .meas_cond_i,
   .cmd_i, .cls_i, .rd_data_o, .rd_valid_o, .status_summary_o);

`default_nettype wire
